/* File: bta_control.sv */
// Master and slave sequencers of the bus translation adapter.
`timescale 1ns/1ps
`include "bta_regs.svh"

module bta_control
    import bta_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        translate_select_n,
    input  wire logic [1:0]  host_size,
    input  wire logic [1:0]  host_addr_low,
    input  wire bta_tgt_in_t tgt_in,
    input  wire logic        sync_termination_n,
    output logic             host_transfer_ack_n,
    output logic             host_transfer_error_ack_n,
    output logic             host_burst_inhibit_n,
    output logic             target_addr_strobe_n,
    output logic             target_data_strobe_n,
    output bta_master_t      master_state,
    output bta_slave_t       slave_phase,
    output bta_term_t        term_captured
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    bta_master_t  master_ff;
    bta_master_t  nxt_master;
    bta_slave_t   slave_ff;
    bta_slave_t   nxt_slave;
    bta_term_t    term_ff;
    bta_tgt_in_t  tgt_meta_ff;
    bta_tgt_in_t  tgt_sync_ff;
    logic         term_prev_ff;
    logic         sync_termination_half_ff;
    logic         delayed_sync_termination_ff;
    logic         line_ff;
    logic         rearmed_ff;
    logic         tack_ff;
    logic         tea_ff;
    logic         tbi_ff;
    logic         strobe_ff;

    wire logic    start_seen;
    wire logic    halt_active;
    wire logic    target_bus_error_active;
    wire logic    autovector_request_active;
    wire logic    dsack_active;
    wire logic    term_now;
    wire logic    term_valid;
    wire logic    cycle_done;
    wire logic    port_fault;
    wire logic    last_cycle;
    wire logic    fault;
    wire bta_port_t port_now;
    wire bta_term_t term_now_info;
    bta_master_t  initial_state;
    bta_master_t  follow_state;

    // ------------------------------------------------------------------------
    // Target-side input synchronisers
    // ------------------------------------------------------------------------

    // Target pins change on the inverted clock; two flops first.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tgt_meta_ff <= '1;
            tgt_sync_ff <= '1;
        end else begin
            tgt_meta_ff <= tgt_in;
            tgt_sync_ff <= tgt_meta_ff;
        end
    end

    // Falling-edge capture gives the half-clock delay.
    always_ff @(negedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_termination_half_ff <= 1'b0;
        end else begin
            sync_termination_half_ff <= ~sync_termination_n;
        end
    end

    // Second flop lands it on the rising edge.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            delayed_sync_termination_ff <= 1'b0;
        end else begin
            delayed_sync_termination_ff <= sync_termination_half_ff;
        end
    end

    // ------------------------------------------------------------------------
    // Termination decode
    // ------------------------------------------------------------------------

    // Halt is sampled only, never driven.
    assign halt_active  = ~tgt_sync_ff.target_halt_n;
    assign target_bus_error_active  = ~tgt_sync_ff.target_bus_error_n;
    assign autovector_request_active  = ~tgt_sync_ff.autovector_request_n;
    assign dsack_active = (tgt_sync_ff.size_acknowledge_n != `BTA_ACK_NONE);
    assign term_now     = target_bus_error_active | autovector_request_active | dsack_active;

    // Two clocks of an asynchronous termination, or one of the delayed sync.
    assign term_valid = (slave_ff == BTA_S_STROBE_WAIT_PHASE) &&
                        ((term_now && term_prev_ff) || delayed_sync_termination_ff);

    // Sync termination and autovector count as a long-word port.
    assign port_now =
        (delayed_sync_termination_ff || autovector_request_active) ? BTA_PORT_LONG :
        (tgt_sync_ff.size_acknowledge_n == `BTA_ACK_BYTE) ? BTA_PORT_BYTE :
        (tgt_sync_ff.size_acknowledge_n == `BTA_ACK_WORD) ? BTA_PORT_WORD :
        BTA_PORT_LONG;

    // Bus error with halt marks a retry.
    assign term_now_info = '{bus_error:  target_bus_error_active && !halt_active,
                             retry:      target_bus_error_active && halt_active,
                             autovector: autovector_request_active,
                             port:       port_now};

    // Last clock's termination level for the two-clock check.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            term_prev_ff <= 1'b0;
        end else begin
            term_prev_ff <= term_now;
        end
    end

    // All termination information is latched on the strobe-to-latched edge.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            term_ff <= '0;
        end else if (term_valid) begin
            term_ff <= term_now_info;
        end
    end

    // ------------------------------------------------------------------------
    // Master sequencer decode
    // ------------------------------------------------------------------------

    // Seven starting cycles chosen by size and address; a line acts as a long.
    always_comb begin
        initial_state = BTA_M_LONG_0;
        unique case (host_size)
            `BTA_SIZ_LONG, `BTA_SIZ_LINE: initial_state = BTA_M_LONG_0;
            `BTA_SIZ_WORD: initial_state = host_addr_low[1] ? BTA_M_WORD2_0 : BTA_M_WORD0_0;
            `BTA_SIZ_BYTE: begin
                unique case (host_addr_low)
                    2'h0: initial_state = BTA_M_BYTE_0;
                    2'h1: initial_state = BTA_M_BYTE_1;
                    2'h2: initial_state = BTA_M_BYTE_2;
                    2'h3: initial_state = BTA_M_BYTE_3;
                endcase
            end
        endcase
    end

    // A follow-on cycle must see the port size that the first cycle saw.
    assign port_fault =
        ((master_ff == BTA_M_LONG_W1) && (term_ff.port != BTA_PORT_WORD)) ||
        (((master_ff == BTA_M_LONG_B1) || (master_ff == BTA_M_LONG_B2) ||
          (master_ff == BTA_M_LONG_B3) || (master_ff == BTA_M_WORD0_B1) ||
          (master_ff == BTA_M_WORD2_B1)) && (term_ff.port != BTA_PORT_BYTE));

    assign fault = term_ff.bus_error || port_fault;

    // Next cycle by termination; each state stands for one target cycle.
    always_comb begin
        follow_state = BTA_M_DONE;
        unique case (master_ff)
            BTA_M_LONG_0: begin
                unique case (term_ff.port)
                    BTA_PORT_WORD: follow_state = BTA_M_LONG_W1;
                    BTA_PORT_BYTE: follow_state = BTA_M_LONG_B1;
                    default:       follow_state = BTA_M_DONE;
                endcase
            end
            BTA_M_LONG_B1: follow_state = BTA_M_LONG_B2;
            BTA_M_LONG_B2: follow_state = BTA_M_LONG_B3;
            BTA_M_WORD0_0: begin
                follow_state = (term_ff.port == BTA_PORT_BYTE) ? BTA_M_WORD0_B1 : BTA_M_DONE;
            end
            BTA_M_WORD2_0: begin
                follow_state = (term_ff.port == BTA_PORT_BYTE) ? BTA_M_WORD2_B1 : BTA_M_DONE;
            end
            default: follow_state = BTA_M_DONE;
        endcase
    end

    assign last_cycle = (follow_state == BTA_M_DONE);
    assign cycle_done = (slave_ff == BTA_S_TERMINATION_LATCHED_PHASE);
    assign start_seen = ~translate_select_n && rearmed_ff &&
                        (slave_ff == BTA_S_SLAVE_IDLE_PHASE);

    // Master next state.
    always_comb begin
        nxt_master = master_ff;
        unique case (master_ff)
            BTA_M_NULL: begin
                if (start_seen) begin
                    nxt_master = initial_state;
                end
            end
            BTA_M_DONE: begin
                if (slave_ff == BTA_S_ACKNOWLEDGE_PHASE) begin
                    nxt_master = BTA_M_NULL;
                end
            end
            BTA_M_ERROR: begin
                if (slave_ff == BTA_S_ERROR_REPORT_PHASE) begin
                    nxt_master = BTA_M_NULL;
                end
            end
            default: begin
                if (cycle_done) begin
                    if (fault) begin
                        nxt_master = BTA_M_ERROR;
                    end else if (term_ff.retry) begin
                        nxt_master = master_ff;
                    end else begin
                        nxt_master = follow_state;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Slave sequencer decode
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_slave = slave_ff;
        unique case (slave_ff)
            BTA_S_SLAVE_IDLE_PHASE: begin
                if ((master_ff != BTA_M_NULL) && (master_ff != BTA_M_DONE) &&
                    (master_ff != BTA_M_ERROR)) begin
                    nxt_slave = BTA_S_STROBE_WAIT_PHASE;
                end
            end
            BTA_S_STROBE_WAIT_PHASE: begin
                if (term_valid) begin
                    nxt_slave = BTA_S_TERMINATION_LATCHED_PHASE;
                end
            end
            BTA_S_TERMINATION_LATCHED_PHASE: begin
                if (fault) begin
                    nxt_slave = BTA_S_ERROR_REPORT_PHASE;
                end else if (term_ff.retry) begin
                    nxt_slave = BTA_S_RETRY_WAIT_PHASE;
                end else if (last_cycle) begin
                    nxt_slave = halt_active ? BTA_S_ACK_HOLD_PHASE :
                                              BTA_S_ACKNOWLEDGE_PHASE;
                end else begin
                    nxt_slave = BTA_S_NEXT_WAIT_PHASE;
                end
            end
            BTA_S_ACK_HOLD_PHASE: begin
                if (!halt_active) begin
                    nxt_slave = BTA_S_ACKNOWLEDGE_PHASE;
                end
            end
            BTA_S_NEXT_WAIT_PHASE: begin
                if (!halt_active) begin
                    nxt_slave = BTA_S_SLAVE_IDLE_PHASE;
                end
            end
            BTA_S_RETRY_WAIT_PHASE: begin
                if (!halt_active) begin
                    nxt_slave = BTA_S_RETRY_EXIT_PHASE;
                end
            end
            BTA_S_ACKNOWLEDGE_PHASE,
            BTA_S_ERROR_REPORT_PHASE,
            BTA_S_RETRY_EXIT_PHASE: nxt_slave = BTA_S_SLAVE_IDLE_PHASE;
        endcase
    end

    // ------------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------------

    // Reset parks both sequencers in idle; reset is input only.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            master_ff <= BTA_M_NULL;
            slave_ff  <= BTA_S_SLAVE_IDLE_PHASE;
        end else begin
            master_ff <= nxt_master;
            slave_ff  <= nxt_slave;
        end
    end

    // Line flag is held for the tenure; rearm blocks a stale select.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            line_ff    <= 1'b0;
            rearmed_ff <= 1'b1;
        end else begin
            if ((master_ff == BTA_M_NULL) && start_seen) begin
                line_ff <= (host_size == `BTA_SIZ_LINE);
            end
            if (translate_select_n) begin
                rearmed_ff <= 1'b1;
            end else if (start_seen) begin
                rearmed_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------------

    // Host terminations and target strobes come from flops.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tack_ff   <= 1'b0;
            tea_ff    <= 1'b0;
            tbi_ff    <= 1'b0;
            strobe_ff <= 1'b0;
        end else begin
            tack_ff   <= (nxt_slave == BTA_S_ACKNOWLEDGE_PHASE);
            tea_ff    <= (nxt_slave == BTA_S_ERROR_REPORT_PHASE);
            tbi_ff    <= (nxt_slave == BTA_S_ACKNOWLEDGE_PHASE) && line_ff;
            strobe_ff <= (nxt_slave == BTA_S_STROBE_WAIT_PHASE) ||
                         (nxt_slave == BTA_S_TERMINATION_LATCHED_PHASE);
        end
    end

    // No cycle-start or buffer-enable output exists.
    assign host_transfer_ack_n       = ~tack_ff;
    assign host_transfer_error_ack_n = ~tea_ff;
    assign host_burst_inhibit_n      = ~tbi_ff;
    assign target_addr_strobe_n      = ~strobe_ff;
    assign target_data_strobe_n      = ~strobe_ff;
    assign master_state              = master_ff;
    assign slave_phase               = slave_ff;
    assign term_captured             = term_ff;

endmodule

/* File: bta_control_assertions.sv */
// Concurrent checks on the ports of the adapter control block.
`timescale 1ns/1ps

module bta_control_checker
    import bta_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        translate_select_n,
    input wire bta_tgt_in_t tgt_in,
    input wire logic        sync_termination_n,
    input wire logic        host_transfer_ack_n,
    input wire logic        host_transfer_error_ack_n,
    input wire logic        host_burst_inhibit_n,
    input wire logic        target_addr_strobe_n,
    input wire bta_master_t master_state,
    input wire bta_slave_t  slave_phase
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // High when no termination is present at the pins.
    wire quiet = tgt_in.target_bus_error_n & tgt_in.autovector_request_n
               & (&tgt_in.size_acknowledge_n) & sync_termination_n;

    // ------------------------------------------------------------------------
    // Sequencer relations
    // ------------------------------------------------------------------------
    a_start_needs_select: assert property ($past(master_state) == BTA_M_NULL
        && master_state != BTA_M_NULL |-> !$past(translate_select_n) && master_state inside
        {BTA_M_LONG_0, BTA_M_WORD0_0, BTA_M_WORD2_0, BTA_M_BYTE_0, BTA_M_BYTE_1,
         BTA_M_BYTE_2, BTA_M_BYTE_3}) else $error("start without select");
    a_strobe_after_master: assert property ($fell(target_addr_strobe_n)
        |-> $past(master_state) != BTA_M_NULL
        && $past(slave_phase) == BTA_S_SLAVE_IDLE_PHASE)
        else $error("early strobe");
    a_no_term_no_latch: assert property (slave_phase == BTA_S_STROBE_WAIT_PHASE && quiet
        && $past(quiet) && $past(quiet, 2) && $past(quiet, 3)
        |=> slave_phase == BTA_S_STROBE_WAIT_PHASE) else $error("latched without term");
    a_latched_branch: assert property (slave_phase == BTA_S_TERMINATION_LATCHED_PHASE
        |=> slave_phase inside {BTA_S_ERROR_REPORT_PHASE, BTA_S_RETRY_WAIT_PHASE,
        BTA_S_ACK_HOLD_PHASE, BTA_S_ACKNOWLEDGE_PHASE, BTA_S_NEXT_WAIT_PHASE})
        else $error("bad latched branch");
    a_retry_master_hold: assert property (slave_phase inside {BTA_S_RETRY_WAIT_PHASE,
        BTA_S_RETRY_EXIT_PHASE} |-> $stable(master_state))
        else $error("retry moved master");
    a_retry_wait_halt: assert property (slave_phase == BTA_S_RETRY_WAIT_PHASE
        && !tgt_in.target_halt_n && !$past(tgt_in.target_halt_n)
        && !$past(tgt_in.target_halt_n, 2) |=> slave_phase == BTA_S_RETRY_WAIT_PHASE)
        else $error("retry left in halt");
    a_retry_exit_idle: assert property (slave_phase == BTA_S_RETRY_EXIT_PHASE
        |=> slave_phase == BTA_S_SLAVE_IDLE_PHASE) else $error("retry exit not idle");
    a_error_to_null: assert property (master_state == BTA_M_ERROR
        |-> ##[1:4] master_state == BTA_M_NULL) else $error("error state stuck");

    // ------------------------------------------------------------------------
    // Host terminations
    // ------------------------------------------------------------------------
    a_ack_in_phase: assert property (!host_transfer_ack_n |-> slave_phase ==
        BTA_S_ACKNOWLEDGE_PHASE ##1 host_transfer_ack_n) else $error("ack misplaced");
    a_tea_in_phase: assert property (!host_transfer_error_ack_n |-> slave_phase ==
        BTA_S_ERROR_REPORT_PHASE ##1 slave_phase == BTA_S_SLAVE_IDLE_PHASE)
        else $error("error ack misplaced");
    a_tbi_with_ack: assert property (!host_burst_inhibit_n |-> !host_transfer_ack_n)
        else $error("inhibit without ack");

    c_line_ack: cover property (!host_transfer_ack_n && !host_burst_inhibit_n);
    c_retry: cover property (slave_phase == BTA_S_RETRY_EXIT_PHASE);
    c_error: cover property (!host_transfer_error_ack_n);
endmodule

bind bta_control bta_control_checker chk_u (.sys_clk, .reset_n, .translate_select_n,
    .tgt_in, .sync_termination_n, .host_transfer_ack_n, .host_transfer_error_ack_n,
    .host_burst_inhibit_n, .target_addr_strobe_n, .master_state, .slave_phase);

/* File: bta_pkg.sv */
// Types shared by the bus translation adapter control block.
package bta_pkg;

    // ------------------------------------------------------------------------
    // Master sequencer: one state per target-side bus cycle.
    // ------------------------------------------------------------------------
    typedef enum logic [4:0] {
        BTA_M_NULL,
        BTA_M_LONG_0,  BTA_M_LONG_W1, BTA_M_LONG_B1, BTA_M_LONG_B2, BTA_M_LONG_B3,
        BTA_M_WORD0_0, BTA_M_WORD0_B1,
        BTA_M_WORD2_0, BTA_M_WORD2_B1,
        BTA_M_BYTE_0,  BTA_M_BYTE_1, BTA_M_BYTE_2, BTA_M_BYTE_3,
        BTA_M_DONE,
        BTA_M_ERROR
    } bta_master_t;

    // ------------------------------------------------------------------------
    // Slave sequencer: clock-by-clock phases inside one master state.
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        BTA_S_SLAVE_IDLE_PHASE,
        BTA_S_STROBE_WAIT_PHASE,
        BTA_S_TERMINATION_LATCHED_PHASE,
        BTA_S_ACK_HOLD_PHASE,
        BTA_S_ACKNOWLEDGE_PHASE,
        BTA_S_NEXT_WAIT_PHASE,
        BTA_S_ERROR_REPORT_PHASE,
        BTA_S_RETRY_WAIT_PHASE,
        BTA_S_RETRY_EXIT_PHASE
    } bta_slave_t;

    // Port size reported by a termination.
    typedef enum logic [1:0] {
        BTA_PORT_LONG,
        BTA_PORT_WORD,
        BTA_PORT_BYTE
    } bta_port_t;

    // Termination captured when the strobe phase ends.
    typedef struct packed {
        logic      bus_error;
        logic      retry;
        logic      autovector;
        bta_port_t port;
    } bta_term_t;

    // Target-side termination pins, active low, as they arrive.
    typedef struct packed {
        logic       target_bus_error_n;
        logic       target_halt_n;
        logic       autovector_request_n;
        logic [1:0] size_acknowledge_n;
    } bta_tgt_in_t;

endpackage

/* File: bta_regs.svh */
// Constants for the bus translation adapter control block.
`ifndef BTA_REGS_SVH
`define BTA_REGS_SVH

// ----------------------------------------------------------------------------
// Host transfer size encodings
// ----------------------------------------------------------------------------
`define BTA_SIZ_LONG  2'h0
`define BTA_SIZ_BYTE  2'h1
`define BTA_SIZ_WORD  2'h2
`define BTA_SIZ_LINE  2'h3

// ----------------------------------------------------------------------------
// Size acknowledge encodings, active low on the pins
// ----------------------------------------------------------------------------
`define BTA_ACK_LONG  2'h0
`define BTA_ACK_WORD  2'h1
`define BTA_ACK_BYTE  2'h2
`define BTA_ACK_NONE  2'h3

`endif

/* File: bta_target_model.sv */
// Target-side system model answering each strobed cycle.
`timescale 1ns/1ps
`include "bta_regs.svh"

module bta_target_model
    import bta_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       target_addr_strobe_n,
    input  wire logic       translate_select_n,
    input  wire logic [1:0] resp_kind,
    input  wire logic [1:0] ack_first,
    input  wire logic [1:0] ack_rest,
    input  wire logic [3:0] resp_delay,
    output bta_tgt_in_t     tgt_in,
    output logic            sync_termination_n
);
    logic [3:0] wait_cnt = 4'h0;
    logic [2:0] cyc = 3'h0;
    logic [2:0] halt_cnt = 3'h0;
    logic       fired = 1'b0;
    logic       cache_burst_request_n = 1'b1;

    initial tgt_in = 5'h1F;
    initial sync_termination_n = 1'b1;

    // Inverted clock; released lines return to pull-up level.
    always @(negedge sys_clk) begin
        #1;
        sync_termination_n = 1'b1;
        if (target_addr_strobe_n && halt_cnt != 3'h0) halt_cnt = halt_cnt - 3'h1;
        tgt_in.target_halt_n = (halt_cnt == 3'h0);
        if (target_addr_strobe_n) begin
            if (fired) cyc = cyc + 3'h1;
            fired = 1'b0;
            wait_cnt = 4'h0;
            tgt_in.target_bus_error_n = 1'b1;
            tgt_in.autovector_request_n = 1'b1;
            tgt_in.size_acknowledge_n = `BTA_ACK_NONE;
        end else if (!fired && wait_cnt == resp_delay) begin
            fired = 1'b1;
            case (resp_kind)
                2'h0: tgt_in.size_acknowledge_n = (cyc == 3'h0) ? ack_first : ack_rest;
                2'h1: tgt_in.target_bus_error_n = 1'b0;
                2'h2: begin
                    if (cyc == 3'h0) begin
                        tgt_in.target_bus_error_n = 1'b0;
                        halt_cnt = 3'h3;
                        tgt_in.target_halt_n = 1'b0;
                    end else begin
                        tgt_in.size_acknowledge_n = ack_rest;
                    end
                end
                default: sync_termination_n = 1'b0;
            endcase
        end else if (!fired) begin
            wait_cnt = wait_cnt + 4'h1;
        end
        if (translate_select_n) cyc = 3'h0;
    end
endmodule

/* File: bta_testbench.sv */
// Self-checking testbench of the adapter control block.
`timescale 1ns/1ps
`include "bta_regs.svh"

module testbench;
    import bta_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        translate_select_n = 1'b1;
    logic [1:0]  host_size = 2'h0;
    logic [1:0]  host_addr_low = 2'h0;
    logic [1:0]  resp_kind = 2'h0;
    logic [1:0]  ack_first = 2'h0;
    logic [1:0]  ack_rest = 2'h0;
    logic [3:0]  resp_delay = 4'h1;
    bta_tgt_in_t tgt_in;
    logic        sync_termination_n;
    logic        ack_n, tea_n, tbi_n, as_n, ds_n;
    bta_master_t master_state;
    bta_slave_t  slave_phase;
    bta_term_t   term_captured;
    int          n_fail = 0;
    int          checks = 0;

    // Clock at 200 MHz.
    always #2.5 sys_clk = ~sys_clk;

    bta_control dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .translate_select_n(translate_select_n), .host_size(host_size),
        .host_addr_low(host_addr_low), .tgt_in(tgt_in),
        .sync_termination_n(sync_termination_n), .host_transfer_ack_n(ack_n),
        .host_transfer_error_ack_n(tea_n), .host_burst_inhibit_n(tbi_n),
        .target_addr_strobe_n(as_n), .target_data_strobe_n(ds_n),
        .master_state(master_state), .slave_phase(slave_phase),
        .term_captured(term_captured));

    bta_target_model tgt_u (.sys_clk(sys_clk), .target_addr_strobe_n(as_n),
        .translate_select_n(translate_select_n), .resp_kind(resp_kind),
        .ack_first(ack_first), .ack_rest(ack_rest), .resp_delay(resp_delay),
        .tgt_in(tgt_in), .sync_termination_n(sync_termination_n));

    task automatic check_vec(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_cnt(input int got, input int exp, input string what);
        checks++;
        if (got != exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // One tenure: select, count strobes, judge the host answer.
    task automatic run(input string name, input logic [1:0] sz, input logic [1:0] ad,
                       input logic [1:0] kind, input logic [1:0] a1, input logic [1:0] a2,
                       input int exp_as, input logic ok, input logic exp_tbi);
        int   n_as = 0;
        logic prev = 1'b1, ack = 1'b1, host_transfer_error_ack = 1'b1, host_burst_inhibit = 1'b1;
        @(posedge sys_clk); #1;
        resp_kind = kind;
        ack_first = a1;
        ack_rest = a2;
        host_size = sz;
        host_addr_low = ad;
        translate_select_n = 1'b0;
        for (int i = 0; i < 400 && ack === 1'b1 && host_transfer_error_ack === 1'b1; i++) begin
            @(posedge sys_clk); #1;
            if (prev && !as_n) n_as++;
            prev = as_n;
            ack = ack_n;
            host_transfer_error_ack = tea_n;
            host_burst_inhibit = tbi_n;
            check_vec(as_n, ds_n, "strobes differ");
        end
        translate_select_n = 1'b1;
        repeat (6) @(posedge sys_clk); #1;
        check_cnt(n_as, exp_as, "strobe count");
        check_vec({ack, host_transfer_error_ack, host_burst_inhibit}, {!ok, ok, exp_tbi}, "host answer");
        check_vec(master_state, BTA_M_NULL, "master null");
        check_vec(slave_phase, BTA_S_SLAVE_IDLE_PHASE, "slave idle");
        $display("test %s done", name);
    endtask

    task automatic t_reset_values();
        check_vec({ack_n, tea_n, tbi_n, as_n, ds_n}, 8'h1F, "outputs in reset");
        check_vec(master_state, BTA_M_NULL, "master in reset");
        check_vec(slave_phase, BTA_S_SLAVE_IDLE_PHASE, "slave in reset");
        check_vec(term_captured, 8'h00, "term in reset");
        $display("test reset values done");
    endtask

    task automatic t_initial_states();
        run("long", `BTA_SIZ_LONG, 2'h0, 2'h0, `BTA_ACK_LONG, `BTA_ACK_LONG, 1, 1, 1);
        run("line", `BTA_SIZ_LINE, 2'h0, 2'h0, `BTA_ACK_LONG, `BTA_ACK_LONG, 1, 1, 0);
        run("word0", `BTA_SIZ_WORD, 2'h0, 2'h0, `BTA_ACK_BYTE, `BTA_ACK_BYTE, 2, 1, 1);
        run("word2", `BTA_SIZ_WORD, 2'h2, 2'h0, `BTA_ACK_BYTE, `BTA_ACK_BYTE, 2, 1, 1);
        for (int a = 0; a < 4; a++) begin
            run("byte", `BTA_SIZ_BYTE, a[1:0], 2'h0, `BTA_ACK_BYTE, `BTA_ACK_BYTE, 1, 1, 1);
        end
    endtask

    task automatic t_dynamic_sizing();
        resp_delay = 4'h6;
        run("long byte", `BTA_SIZ_LONG, 2'h0, 2'h0, `BTA_ACK_BYTE, `BTA_ACK_BYTE, 4, 1, 1);
        resp_delay = 4'h1;
        run("long word", `BTA_SIZ_LONG, 2'h0, 2'h0, `BTA_ACK_WORD, `BTA_ACK_WORD, 2, 1, 1);
        run("size change", `BTA_SIZ_LONG, 2'h0, 2'h0, `BTA_ACK_BYTE, `BTA_ACK_WORD, 2, 0, 1);
    endtask

    task automatic t_faults();
        run("bus error", `BTA_SIZ_LONG, 2'h0, 2'h1, `BTA_ACK_LONG, `BTA_ACK_LONG, 1, 0, 1);
        run("retry", `BTA_SIZ_LONG, 2'h0, 2'h2, `BTA_ACK_BYTE, `BTA_ACK_BYTE, 5, 1, 1);
        run("sync long", `BTA_SIZ_LONG, 2'h0, 2'h3, `BTA_ACK_NONE, `BTA_ACK_NONE, 1, 1, 1);
        run("sync word", `BTA_SIZ_WORD, 2'h2, 2'h3, `BTA_ACK_NONE, `BTA_ACK_NONE, 1, 1, 1);
    endtask

    task automatic t_reset_mid();
        resp_delay = 4'hF;
        @(posedge sys_clk); #1;
        translate_select_n = 1'b0;
        repeat (6) @(posedge sys_clk); #1;
        reset_n = 1'b0;
        #1;
        check_vec({ack_n, tea_n, as_n}, 8'h07, "mid reset outs");
        check_vec(master_state, BTA_M_NULL, "mid reset master");
        repeat (2) @(posedge sys_clk); #1;
        reset_n = 1'b1;
        translate_select_n = 1'b1;
        resp_delay = 4'h1;
        repeat (4) @(posedge sys_clk); #1;
        check_vec(slave_phase, BTA_S_SLAVE_IDLE_PHASE, "mid reset slave");
        $display("test reset mid done");
    endtask

    // Watchdog well above the expected run length.
    initial begin
        #100000;
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end

    // Main sequence.
    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        t_reset_values();
        reset_n = 1'b1;
        t_initial_states();
        t_dynamic_sizing();
        t_faults();
        t_reset_mid();
        run("after reset", `BTA_SIZ_LONG, 2'h0, 2'h0, `BTA_ACK_LONG, `BTA_ACK_LONG, 1, 1, 1);
        finish_test();
    end
endmodule
